// ===== perf_counter_channel.sv
// Shared constants and types, plus one performance counter channel
package perf_pkg;
    // Counter geometry
    localparam int COUNTER_WIDTH      = 32;
    localparam int NUM_CHANNELS       = 4;
    localparam int NUM_REQUESTERS     = 4;
    // Channel index of channel_three, first channel with bus events
    localparam int FIRST_BUS_CHANNEL  = 2;
    // Clock periods, and the bus tick derived from them
    localparam int CPU_CLOCK_PERIOD_NS    = 5;
    localparam int SYSBUS_CLOCK_PERIOD_NS = 10;
    localparam int SYSBUS_DIVIDE =
        (SYSBUS_CLOCK_PERIOD_NS + CPU_CLOCK_PERIOD_NS - 1)
        / CPU_CLOCK_PERIOD_NS;
    localparam int DIV_WIDTH = 8;

    // Event selection per channel
    typedef enum logic [3:0] {
        EV_NONE,
        EV_XY_WRITE,
        EV_U_READ,
        EV_U_WRITE,
        EV_OC_READ_MISS,
        EV_OC_WRITE_MISS,
        EV_OP_READ_WAIT,
        EV_OP_WRITE_WAIT,
        EV_CRM_WAIT,
        EV_CWM_WAIT,
        EV_BUS_REQ,
        EV_BUS_RSP,
        EV_REQ_WAIT,
        EV_RSP_WAIT
    } event_sel_t;

    // Operand path and cache activity, one cycle per event
    typedef struct packed {
        logic xy_write_opbus;    // Operand bus write to XY memory
        logic xy_write_xybus;    // XY bus write to XY memory
        logic x_move;            // x_move_instruction accesses XY
        logic x_move_write;      // That access is a write
        logic y_move;            // y_move_instruction accesses XY
        logic y_move_write;      // That access is a write
        logic u_read;            // Operand read of U-memory
        logic u_write;           // Operand write of U-memory
        logic u_via_cache;       // U-memory access came through cache
        logic oc_read_miss;      // Read miss going outside the core
        logic oc_write_miss;     // Write miss going outside the core
        logic write_through;     // Write is a write-through access
        logic preload;           // Miss caused by cache_preload_instruction
        logic op_read_wait;      // Operand read wait cycle
        logic op_write_wait;     // Operand write wait cycle
        logic read_miss_wait;    // Wait due to operand read miss
        logic fill_contention;   // Line fill wait overlapping by contention
        logic write_miss_wait;   // Wait due to operand write miss
    } operand_events_t;

    // System bus handshakes, one bit per requester
    typedef struct packed {
        logic [NUM_REQUESTERS-1:0] transfer_ask;
        logic [NUM_REQUESTERS-1:0] acceptance_signal;
        logic [NUM_REQUESTERS-1:0] reply_ask;
        logic [NUM_REQUESTERS-1:0] reply_acceptance;
    } sysbus_t;
endpackage

`timescale 1ns/1ps

module perf_counter_channel #(
    parameter int WIDTH = perf_pkg::COUNTER_WIDTH
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Control
    input  wire logic             clear,
    input  wire logic             step,
    // Result
    output logic [WIDTH-1:0]      value_reg,
    output logic                  overflow_reg,
    output logic                  carry
);
    localparam logic [WIDTH-1:0] ALL_ONES = '1;
    localparam logic [WIDTH-1:0] ONE      = WIDTH'(1);

    // Wrap of this counter, feeds the upper half of a pair
    assign carry = step && (value_reg == ALL_ONES);

    ////////////////////////////////////////////////////////////////////
    // Count value; clear has priority since host wants a fresh start
    always_ff @(posedge clock) begin
        if (rst || clear) begin
            value_reg <= '0;
        end else if (step) begin
            value_reg <= value_reg + ONE;
        end
    end

    // Sticky overflow; a wrap in the clearing cycle is kept
    always_ff @(posedge clock) begin
        if (rst) begin
            overflow_reg <= 1'b0;
        end else if (carry) begin
            overflow_reg <= 1'b1;
        end else if (clear) begin
            overflow_reg <= 1'b0;
        end
    end
endmodule

// ===== perf_event_unit.sv
// Event qualification and counter channels for operand and bus events
//
// Functional notes
// - XY write counts XY and operand bus
// - Simultaneous x/y moves count once only
// - U-memory reads, writes separate, cache excluded
// - Read miss counts once per external access
// - Preload misses never counted as misses
// - Write miss excludes write-through accesses
// - Operand read, write wait cycles counted
// - Read miss wait includes fill contention
// - Every write miss wait cycle counted
// - Bus events only on channels three, four
// - Bus cells sampled on bus clock tick
// - Request wait: ask without acceptance counted
// - Response wait: reply without acceptance counted
// - Many waiting requests add one per bus tick
// - 32-bit counters, pairs join to 64
// - CPU events halt while CPU sleeps
`timescale 1ns/1ps

module perf_event_unit #(
    parameter int NCH   = perf_pkg::NUM_CHANNELS,
    parameter int WIDTH = perf_pkg::COUNTER_WIDTH,
    parameter int BUS_DIVIDE = perf_pkg::SYSBUS_DIVIDE
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst,
    // Core activity
    input  wire perf_pkg::operand_events_t   op_events,
    input  wire logic                        cpu_sleep,
    // System bus handshakes
    input  wire perf_pkg::sysbus_t           bus,
    // Host control
    input  wire perf_pkg::event_sel_t [NCH-1:0] chan_select,
    input  wire logic [NCH-1:0]              chan_clear,
    input  wire logic [NCH/2-1:0]            pair_extend,
    // Host results
    output logic [NCH-1:0][WIDTH-1:0]        chan_value,
    output logic [NCH-1:0]                   chan_overflow,
    output logic                             bus_tick
);
    localparam logic [perf_pkg::DIV_WIDTH-1:0] DIV_LAST =
        perf_pkg::DIV_WIDTH'(BUS_DIVIDE - 1);
    localparam logic [perf_pkg::DIV_WIDTH-1:0] DIV_ONE =
        perf_pkg::DIV_WIDTH'(1);

    ////////////////////////////////////////////////////////////////////
    // Bus clock rate as a one-cycle enable from a divider

    logic [perf_pkg::DIV_WIDTH-1:0] div_reg;   // Divider phase

    // Free-running divider; bus logic only looks at inputs on the tick
    always_ff @(posedge clock) begin
        if (rst) begin
            div_reg <= '0;
        end else if (div_reg == DIV_LAST) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + DIV_ONE;
        end
    end

    assign bus_tick = (div_reg == DIV_LAST);

    ////////////////////////////////////////////////////////////////////
    // CPU-side event qualification

    logic ev_xy_write;      // XY memory write access
    logic ev_u_read;        // U-memory operand read
    logic ev_u_write;       // U-memory operand write
    logic ev_rd_miss;       // Operand read miss
    logic ev_wr_miss;       // Operand write miss
    logic ev_rd_wait;       // Operand read wait cycle
    logic ev_wr_wait;       // Operand write wait cycle
    logic ev_rm_wait;       // Read miss wait cycle
    logic ev_wm_wait;       // Write miss wait cycle
    logic cpu_run;          // CPU clock is running

    assign cpu_run = !cpu_sleep;

    always_comb begin
        ev_xy_write = op_events.xy_write_opbus
                   || op_events.xy_write_xybus
                   || (op_events.x_move && op_events.x_move_write)
                   || (op_events.y_move && op_events.y_move_write);
        if (op_events.x_move && op_events.y_move) begin
            ev_xy_write = 1'b1;
        end
        ev_u_read  = op_events.u_read  && !op_events.u_via_cache;
        ev_u_write = op_events.u_write && !op_events.u_via_cache;
        ev_rd_miss = op_events.oc_read_miss && !op_events.preload;
        ev_wr_miss = op_events.oc_write_miss && !op_events.preload
                  && !op_events.write_through;
        ev_rd_wait = op_events.op_read_wait;
        ev_wr_wait = op_events.op_write_wait;
        ev_rm_wait = op_events.read_miss_wait
                  || op_events.fill_contention;
        ev_wm_wait = op_events.write_miss_wait;
    end

    ////////////////////////////////////////////////////////////////////
    // System bus event qualification, valid only on the tick

    logic ev_bus_req;       // Request cell accepted
    logic ev_bus_rsp;       // Response cell accepted
    logic ev_req_wait;      // Some request still waiting
    logic ev_rsp_wait;      // Some response still waiting

    // Count a waiting channel once however many requesters wait
    function automatic logic any_waiting(
        input logic [perf_pkg::NUM_REQUESTERS-1:0] ask,
        input logic [perf_pkg::NUM_REQUESTERS-1:0] accept
    );
        any_waiting = |(ask & ~accept);
    endfunction

    // A cell is one accepted transfer seen on a bus clock
    function automatic logic any_cell(
        input logic [perf_pkg::NUM_REQUESTERS-1:0] ask,
        input logic [perf_pkg::NUM_REQUESTERS-1:0] accept
    );
        any_cell = |(ask & accept);
    endfunction

    always_comb begin
        ev_bus_req  = bus_tick
                   && any_cell(bus.transfer_ask, bus.acceptance_signal);
        ev_bus_rsp  = bus_tick
                   && any_cell(bus.reply_ask, bus.reply_acceptance);
        ev_req_wait = bus_tick
                   && any_waiting(bus.transfer_ask, bus.acceptance_signal);
        ev_rsp_wait = bus_tick
                   && any_waiting(bus.reply_ask, bus.reply_acceptance);
    end

    ////////////////////////////////////////////////////////////////////
    // Event picked by one channel's selection

    function automatic logic select_event(
        input perf_pkg::event_sel_t sel,
        input logic                 bus_allowed,
        input logic [8:0]           cpu_ev,
        input logic [3:0]           bus_ev
    );
        logic picked;
        picked = 1'b0;
        case (sel)
            perf_pkg::EV_XY_WRITE:      picked = cpu_ev[0];
            perf_pkg::EV_U_READ:        picked = cpu_ev[1];
            perf_pkg::EV_U_WRITE:       picked = cpu_ev[2];
            perf_pkg::EV_OC_READ_MISS:  picked = cpu_ev[3];
            perf_pkg::EV_OC_WRITE_MISS: picked = cpu_ev[4];
            perf_pkg::EV_OP_READ_WAIT:  picked = cpu_ev[5];
            perf_pkg::EV_OP_WRITE_WAIT: picked = cpu_ev[6];
            perf_pkg::EV_CRM_WAIT:      picked = cpu_ev[7];
            perf_pkg::EV_CWM_WAIT:      picked = cpu_ev[8];
            // Bus selections only where the channel offers them
            perf_pkg::EV_BUS_REQ:       picked = bus_allowed && bus_ev[0];
            perf_pkg::EV_BUS_RSP:       picked = bus_allowed && bus_ev[1];
            perf_pkg::EV_REQ_WAIT:      picked = bus_allowed && bus_ev[2];
            perf_pkg::EV_RSP_WAIT:      picked = bus_allowed && bus_ev[3];
            // No selection: channel holds its value
            default:                    picked = 1'b0;
        endcase
        select_event = picked;
    endfunction

    logic [8:0] cpu_ev;     // Gated CPU-side events
    logic [3:0] bus_ev;     // Bus-side events

    // Bus events keep running in sleep; only the CPU clock stops
    assign cpu_ev = cpu_run ? {ev_wm_wait, ev_rm_wait, ev_wr_wait,
                               ev_rd_wait, ev_wr_miss, ev_rd_miss,
                               ev_u_write, ev_u_read, ev_xy_write}
                            : 9'h000;
    assign bus_ev = {ev_rsp_wait, ev_req_wait, ev_bus_rsp, ev_bus_req};

    ////////////////////////////////////////////////////////////////////
    // Counter channels, lower/upper pairs joinable

    logic [NCH-1:0] chan_step;    // Increment this cycle
    logic [NCH-1:0] chan_carry;   // Wrap out of each channel
    logic [NCH-1:0] own_event;    // Event of the channel's own selection

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            own_event[c] = select_event(chan_select[c],
                                        c >= perf_pkg::FIRST_BUS_CHANNEL,
                                        cpu_ev, bus_ev);
        end
    end

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            if ((c % 2 == 1) && pair_extend[c / 2]) begin
                chan_step[c] = chan_carry[c - 1];
            end else begin
                chan_step[c] = own_event[c];
            end
        end
    end

    // One counter per channel; a cleared pair needs both halves cleared
    for (genvar g = 0; g < NCH; g++) begin : gen_chan
        perf_counter_channel #(
            .WIDTH        (WIDTH)
        ) u_counter (
            .clock        (clock),
            .rst          (rst),
            .clear        (chan_clear[g]),
            .step         (chan_step[g]),
            .value_reg    (chan_value[g]),
            .overflow_reg (chan_overflow[g]),
            .carry        (chan_carry[g])
        );
    end
endmodule

// ===== perf_event_unit_sva.sv
// Checker of event counting at the event unit's ports
`timescale 1ns/1ps

module perf_event_unit_sva #(
    parameter int NCH        = 4,
    parameter int WIDTH      = 32,
    parameter int BUS_DIVIDE = 2
) (
    // Clock and reset
    input wire logic                            clock,
    input wire logic                            rst,
    // Stimulus seen by the unit
    input wire perf_pkg::operand_events_t       op_events,
    input wire logic                            cpu_sleep,
    input wire perf_pkg::sysbus_t               bus,
    input wire perf_pkg::event_sel_t [NCH-1:0]  chan_select,
    input wire logic [NCH-1:0]                  chan_clear,
    input wire logic [NCH/2-1:0]                pair_extend,
    // Results
    input wire logic [NCH-1:0][WIDTH-1:0]       chan_value,
    input wire logic [NCH-1:0]                  chan_overflow,
    input wire logic                            bus_tick
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Short names for the channels under watch
    wire [WIDTH-1:0] v0 = chan_value[0];
    wire [WIDTH-1:0] v1 = chan_value[1];
    wire [WIDTH-1:0] v2 = chan_value[2];
    wire [WIDTH-1:0] v3 = chan_value[3];
    // Any requester waiting, reduced to one bit
    wire req_wait = |(bus.transfer_ask & ~bus.acceptance_signal);
    wire rsp_wait = |(bus.reply_ask & ~bus.reply_acceptance);

    a_hold_unselected: assert property (chan_select[0] == perf_pkg::EV_NONE
        && !chan_clear[0] |=> $stable(v0)) else $error("held value moved");
    a_clear_zeroes: assert property (chan_clear[0] |=> v0 == '0)
        else $error("clear ignored");
    a_u_read_step: assert property (chan_select[0] == perf_pkg::EV_U_READ
        && op_events.u_read && !op_events.u_via_cache && !cpu_sleep
        && !chan_clear[0] |=> v0 == $past(v0) + 1'b1)
        else $error("u read missed");
    a_sleep_halts: assert property (cpu_sleep && !chan_clear[0]
        && chan_select[0] < perf_pkg::EV_BUS_REQ |=> $stable(v0))
        else $error("count in sleep");
    a_low_no_bus: assert property (chan_select[1] >= perf_pkg::EV_BUS_REQ
        && !chan_clear[1] && !pair_extend[0] |=> $stable(v1))
        else $error("bus event on low channel");
    a_req_wait_once: assert property (chan_select[2] == perf_pkg::EV_REQ_WAIT
        && bus_tick && req_wait && !chan_clear[2]
        |=> v2 == $past(v2) + 1'b1) else $error("request wait");
    a_rsp_wait_once: assert property (chan_select[3] == perf_pkg::EV_RSP_WAIT
        && bus_tick && rsp_wait && !chan_clear[3] && !pair_extend[1]
        |=> v3 == $past(v3) + 1'b1) else $error("response wait");
    a_bus_tick_only: assert property (chan_select[2] >= perf_pkg::EV_BUS_REQ
        && !bus_tick && !chan_clear[2] |=> $stable(v2))
        else $error("bus count off tick");
    a_tick_spacing: assert property (bus_tick |=> !bus_tick ##1 bus_tick)
        else $error("bus tick spacing");
    a_xy_pair_once: assert property (chan_select[0] == perf_pkg::EV_XY_WRITE
        && op_events.x_move && op_events.y_move && !cpu_sleep
        && !chan_clear[0] |=> v0 == $past(v0) + 1'b1)
        else $error("xy pair count");

    c_xy_pair: cover property (op_events.x_move && op_events.y_move);
    c_req_wait: cover property (bus_tick && req_wait);
    c_sleep: cover property (cpu_sleep && op_events.u_read);
endmodule

bind perf_event_unit perf_event_unit_sva #(.NCH(NCH), .WIDTH(WIDTH),
    .BUS_DIVIDE(BUS_DIVIDE)) sva_u (.clock(clock), .rst(rst),
    .op_events(op_events), .cpu_sleep(cpu_sleep), .bus(bus),
    .chan_select(chan_select), .chan_clear(chan_clear),
    .pair_extend(pair_extend), .chan_value(chan_value),
    .chan_overflow(chan_overflow), .bus_tick(bus_tick));

// ===== perf_host_model.sv
// Emulator host model: picks events and clears counters
`timescale 1ns/1ps

module perf_host_model (
    // Clock
    input  wire logic                          clock,
    // Host control
    output perf_pkg::event_sel_t [3:0]         chan_select,
    output logic [3:0]                         chan_clear,
    output logic [1:0]                         pair_extend
);
    // Idle host selects nothing
    initial begin
        chan_select = '{default: perf_pkg::EV_NONE};
        chan_clear  = '0;
        pair_extend = '0;
    end
    // New selection always starts from cleared counters, one cycle pulse
    task automatic configure(input perf_pkg::event_sel_t [3:0] s,
                             input logic [1:0] px);
        @(posedge clock);
        chan_select <= s;
        pair_extend <= px;
        chan_clear  <= 4'hf;
        @(posedge clock);
        chan_clear  <= 4'h0;
    endtask
endmodule

// ===== perf_event_unit_test.sv
// Self-checking bench of the event unit
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end

module perf_event_unit_test;
    logic                        clock = 1'b0;
    logic                        rst = 1'b1;
    perf_pkg::operand_events_t   op_events = '0;
    logic                        cpu_sleep = 1'b0;
    perf_pkg::sysbus_t           bus = '0;
    perf_pkg::event_sel_t [3:0]  chan_select;
    logic [3:0]                  chan_clear;
    logic [1:0]                  pair_extend;
    logic [3:0][31:0]            chan_value;
    logic [3:0]                  chan_overflow;
    logic                        bus_tick;
    int                          n_errors = 0;
    int                          total_checks = 0;

    // 200 MHz clock
    initial begin
        forever #2.5 clock = ~clock;
    end

    perf_host_model host_u (.clock(clock), .chan_select(chan_select),
        .chan_clear(chan_clear), .pair_extend(pair_extend));
    perf_event_unit dut_u (.clock(clock), .rst(rst), .op_events(op_events),
        .cpu_sleep(cpu_sleep), .bus(bus), .chan_select(chan_select),
        .chan_clear(chan_clear), .pair_extend(pair_extend),
        .chan_value(chan_value), .chan_overflow(chan_overflow),
        .bus_tick(bus_tick));

    // One cycle of core activity
    task automatic op(input perf_pkg::operand_events_t e);
        @(posedge clock);
        op_events <= e;
    endtask
    // Drop all activity, let the last count land, then look
    task automatic settle();
        op('0);
        bus <= '0;
        @(posedge clock);
        #1;
    endtask
    // Bus pattern held for four cycles, so exactly two ticks
    task automatic bus_for(input perf_pkg::sysbus_t v);
        @(posedge clock);
        bus <= v;
        repeat (3) @(posedge clock);
    endtask
    task automatic t_xy();
        host_u.configure('{perf_pkg::EV_NONE, perf_pkg::EV_NONE,
            perf_pkg::EV_NONE, perf_pkg::EV_XY_WRITE}, 2'h0);
        op(18'h20000); op(18'h10000); op(18'h0a000); op(18'h0c000);
        settle();
        `CHK(chan_value[0], 32'h4)
    endtask
    // Upper half of an extended pair must ignore its own select
    task automatic t_u();
        host_u.configure('{perf_pkg::EV_U_WRITE, perf_pkg::EV_U_READ,
            perf_pkg::EV_U_WRITE, perf_pkg::EV_U_READ}, 2'h2);
        op(18'h00800); op(18'h00400); op(18'h00a00); op(18'h00600);
        settle();
        `CHK(chan_value, {32'h0, 32'h1, 32'h1, 32'h1})
    endtask
    task automatic t_miss();
        host_u.configure('{perf_pkg::EV_NONE, perf_pkg::EV_NONE,
            perf_pkg::EV_OC_WRITE_MISS, perf_pkg::EV_OC_READ_MISS}, 2'h0);
        op(18'h00100); op(18'h00120); op(18'h00080); op(18'h000c0);
        op(18'h000a0);
        settle();
        `CHK(chan_value[1:0], {32'h1, 32'h1})
    endtask
    task automatic t_wait();
        host_u.configure('{perf_pkg::EV_CWM_WAIT, perf_pkg::EV_CRM_WAIT,
            perf_pkg::EV_OP_WRITE_WAIT, perf_pkg::EV_OP_READ_WAIT}, 2'h0);
        op(18'h0001b); op(18'h00004);
        settle();
        `CHK(chan_value, {32'h1, 32'h2, 32'h1, 32'h1})
    endtask
    // Several waiting requesters still give one count per bus tick
    task automatic t_bus();
        host_u.configure('{perf_pkg::EV_RSP_WAIT, perf_pkg::EV_REQ_WAIT,
            perf_pkg::EV_BUS_REQ, perf_pkg::EV_REQ_WAIT}, 2'h0);
        bus_for(16'h30f1);
        settle();
        `CHK(chan_value, {32'h2, 32'h2, 32'h0, 32'h0})
        host_u.configure('{perf_pkg::EV_BUS_RSP, perf_pkg::EV_BUS_REQ,
            perf_pkg::EV_BUS_RSP, perf_pkg::EV_NONE}, 2'h0);
        bus_for(16'h1122);
        settle();
        `CHK(chan_value, {32'h2, 32'h2, 32'h0, 32'h0})
    endtask
    // Sleep stops core events but bus events keep counting
    task automatic t_sleep();
        host_u.configure('{perf_pkg::EV_NONE, perf_pkg::EV_BUS_REQ,
            perf_pkg::EV_NONE, perf_pkg::EV_U_READ}, 2'h0);
        cpu_sleep <= 1'b1;
        op(18'h00800);
        bus_for(16'h1100);
        settle();
        cpu_sleep <= 1'b0;
        `CHK(chan_value[2], 32'h2)
        `CHK(chan_value[0], 32'h0)
    endtask

    task automatic final_report();
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watchdog well past the expected run length
    initial begin
        repeat (3000) @(posedge clock);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        #1;
        `CHK(chan_value, 128'h0)
        t_xy();
        t_u();
        t_miss();
        t_wait();
        t_bus();
        t_sleep();
        // No short scenario comes near a wrap, so every flag stays low
        `CHK(chan_overflow, 4'h0)
        final_report();
    end
endmodule
